/* char_skew.sv */
module char_skew #(
  parameter int DEPTH = 3
) (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       char_clk_en,
  input  wire logic       din,
  input  wire logic [1:0] skew,
  output logic            dout
);

  logic [DEPTH-1:0] stage_q;

  // Each stage advances by one character clock.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stage_q <= '0;
    end else if (char_clk_en) begin
      stage_q <= {stage_q[DEPTH-2:0], din};
    end
  end

  always_comb begin
    if (skew == 2'h0) begin
      dout = din;
    end else begin
      dout = stage_q[skew - 2'h1];
    end
  end

endmodule

/* compat_regs_asserts.sv */
module compat_regs_asserts (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic [15:0] io_addr,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [7:0]  io_rdata,
  input wire logic        mono_mode,
  input wire logic        vdisp_end,
  input wire logic        alpha_mode,
  input wire logic [15:0] font_plane2_base,
  input wire logic [8:0]  h_total_chars,
  input wire logic [1:0]  write_mode,
  input wire logic        irq_out,
  input wire logic        irq_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  font_aligned_a: assert property (font_plane2_base[12:0] == 13'h0000 && !font_plane2_base[15])
    else $error("font base off an 8 KB region");
  alpha_off_a: assert property (!alpha_mode |-> font_plane2_base == 16'h0000)
    else $error("font base set while alpha mode is off");
  htotal_write_a: assert property ($changed(h_total_chars) |-> $past(io_wr) && h_total_chars >= 9'h002)
    else $error("horizontal total moved without a write");
  wmode_legal_a: assert property (write_mode != 2'h3)
    else $error("write mode 3 reached the output");
  wmode_write_a: assert property ($changed(write_mode) |-> $past(io_wr) && $past(io_addr) == 16'h03CF)
    else $error("write mode moved without a write");
  // Read data must stand between reads, since the host may sample it late.
  rdata_hold_a: assert property (!$past(io_rd) |-> $stable(io_rdata))
    else $error("read data changed without a read");
  port_select_a: assert property (io_rd && io_addr != (mono_mode ? 16'h03B5 : 16'h03D5) |=> io_rdata == 8'h00)
    else $error("inactive port read returned data");
  irq_set_a: assert property ($rose(irq_out) |-> $past(vdisp_end))
    else $error("interrupt latch set without end of display");
  irq_clear_a: assert property ($fell(irq_out) |-> irq_oe)
    else $error("interrupt latch cleared while output floats");
  irq_oe_write_a: assert property ($changed(irq_oe) |-> $past(io_wr))
    else $error("interrupt buffer enable moved without a write");

  cover property ($rose(irq_out));
  cover property ($fell(irq_out));
  cover property (write_mode == 2'h2);
endmodule

bind legacy_compat_display_regs compat_regs_asserts compat_regs_asserts_i (.*);

/* compat_regs_params.svh */
`ifndef COMPAT_REGS_PARAMS_SVH
`define COMPAT_REGS_PARAMS_SVH

// Host I/O port addresses.
`define IO_SEQ_INDEX        16'h03C4
`define IO_SEQ_DATA         16'h03C5
`define IO_CRT_INDEX_MONO   16'h03B4
`define IO_CRT_DATA_MONO    16'h03B5
`define IO_CRT_INDEX_COLOR  16'h03D4
`define IO_CRT_DATA_COLOR   16'h03D5
`define IO_GFX_INDEX        16'h03CE
`define IO_GFX_DATA         16'h03CF
`define IO_ATTR_PORT_A      16'h03C0
`define IO_ATTR_PORT_B      16'h03C1

// Sequencer indexes.
`define SEQ_CLOCKING_MODE   3'h1
`define SEQ_FONT_MAP_SELECT 3'h3
`define SEQ_MEMORY_MODE     3'h4

// Timing-controller indexes.
`define CRT_HORIZONTAL_TOTAL 5'h00
`define CRT_HBLANK_END       5'h03
`define CRT_HRETRACE_END     5'h05
`define CRT_VERTICAL_TOTAL   5'h06
`define CRT_OVERFLOW_BITS    5'h07
`define CRT_PRESET_ROW       5'h08
`define CRT_MAX_SCAN_LINE    5'h09
`define CRT_CURSOR_FIRST_ROW 5'h0A
`define CRT_CURSOR_LAST_ROW  5'h0B
`define CRT_VRETRACE_BEGIN   5'h10
`define CRT_VRETRACE_FINISH  5'h11
`define CRT_UNDERLINE_ROW    5'h14
`define CRT_VBLANK_END       5'h16
`define CRT_MODE_CONTROL     5'h17

// Graphics and attribute indexes.
`define GFX_READ_PLANE_SELECT 4'h4
`define GFX_WRITE_MODE        4'h5
`define ATTR_MODE_CONTROL     5'h10
`define ATTR_BORDER_COLOUR    5'h11
`define ATTR_PLANE_ENABLE     5'h12

// Field positions and constants.
`define VRF_IRQ_ARM_BIT     4
`define VRF_IRQ_TRISTATE    5
`define MEM_MODE_ALPHA_BIT  0
`define HRE_ODD_START_BIT   7
`define FONT_REGION_SHIFT   13
`define HTOTAL_BIAS         9'h002
`define REG_RESET           8'h00
`define READ_IDLE_VALUE     8'h00

`endif

/* compat_regs_pkg.sv */
package compat_regs_pkg;

  typedef logic [5:0] colour_t;

  typedef struct packed {
    logic [2:0]         seq_idx;
    logic [7:0]         seq_clocking_mode;
    logic [7:0]         seq_font_map_select;
    logic [7:0]         seq_memory_mode;
    logic [4:0]         crt_index_pointer;
    logic [7:0]         crt_horizontal_total;
    logic [7:0]         crt_hblank_end;
    logic [7:0]         crt_hretrace_end;
    logic [7:0]         crt_vertical_total;
    logic [7:0]         crt_overflow_bits;
    logic [7:0]         crt_preset_row;
    logic [7:0]         crt_max_scan_line;
    logic [7:0]         crt_cursor_first_row;
    logic [7:0]         crt_cursor_last_row;
    logic [7:0]         crt_vretrace_begin;
    logic [7:0]         crt_vretrace_finish;
    logic [7:0]         crt_underline_row;
    logic [7:0]         crt_vblank_end;
    logic [7:0]         crt_mode_control;
    logic [3:0]         gfx_idx;
    logic [7:0]         gfx_read_plane_select;
    logic [7:0]         gfx_write_mode;
    logic               attr_data_phase;
    logic [4:0]         attr_idx;
    logic [15:0][5:0]   attr_palette_entries;
    logic [7:0]         attr_mode_control;
    logic [7:0]         attr_border_colour;
    logic [7:0]         attr_plane_enable;
    logic               irq_latch;
    logic               pen_prev;
    logic [15:0]        pen_latch;
    logic [7:0]         rdata;
    colour_t            pixel;
    logic [1:0]         status_video;
  } state_t;

endpackage

/* host_io.sv */
module host_io (
  input  wire logic        sys_clk,
  input  wire logic [7:0]  io_rdata,
  output logic      [15:0] io_addr,
  output logic             io_wr,
  output logic             io_rd,
  output logic      [7:0]  io_wdata,
  output logic             attr_flipflop_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    io_addr = 16'h0000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
    attr_flipflop_reset = 1'b0;
  end
  // Released lines show the inverse, so stale data never looks valid.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge sys_clk);
    io_wr = 1'b0;
    io_addr = ~a;
    io_wdata = ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge sys_clk);
    io_rd = 1'b0;
    io_addr = ~a;
    d = io_rdata;
  endtask
  task automatic pair(input logic [15:0] p, input logic [7:0] i, input logic [7:0] d);
    wr(p, i);
    wr(p + 16'h0001, d);
  endtask
  task automatic attr(input logic [4:0] i, input logic [7:0] d, input logic b);
    @(negedge sys_clk);
    attr_flipflop_reset = 1'b1;
    @(negedge sys_clk);
    attr_flipflop_reset = 1'b0;
    wr(b ? 16'h03C1 : 16'h03C0, {3'b000, i});
    wr(b ? 16'h03C1 : 16'h03C0, d);
  endtask
  task automatic init;
    pair(16'h03C4, 8'h01, 8'h00);
  endtask
endmodule

/* legacy_compat_display_regs.sv */
`include "compat_regs_params.svh"

// Contract
// RULE1 - Font map A picks one of four 8 KB plane-2 regions by bits 3:2.
// RULE2 - Font map B picks one of four 8 KB plane-2 regions by bits 1:0.
// RULE3 - Attribute bit 3 of each character chooses map A or map B.
// RULE4 - Memory mode bit 0 turns alpha mode and font selection on or off.
// RULE5 - Timing index and data sit at 3B4/3B5 mono, 3D4/3D5 colour.
// RULE6 - Timing index uses five low bits; upper three are unused.
// RULE7 - Horizontal total holds character times per line minus two.
// RULE8 - Blank end gives enable skew 0..3 and blank-off character count.
// RULE9 - Retrace end bit 7 picks odd or even start address after retrace.
// RULE10 - Vertical total holds frame length low eight bits in scan lines.
// RULE11 - Cursor end bits 6:5 skew cursor: 0, 0, 1 or 2 clocks.
// RULE12 - Software writes cursor end row as last shown row plus one.
// RULE13 - Indexes 10 and 11 write retrace; reads return light-pen bytes.
// RULE14 - Retrace start holds low eight bits of its scan line.
// RULE15 - Bit 5 low drives interrupt output from latch; high floats it.
// RULE16 - Bit 4 low clears latch when bit 5 low; high sets at display end.
// RULE17 - Software writes underline row as desired row minus one.
// RULE18 - Read plane select bits 2:0 name the plane a read returns.
// RULE19 - Write mode codes 0,1,2 select modes; code 3 acts as mode 1.
// RULE20 - Sixteen palette entries drive six colour outputs, one means on.
// RULE21 - Border colour uses palette encoding; zero for monochrome displays.
// RULE22 - Plane enable bits 5:4 route two colour signals to status bits.
// RULE23 - Attribute index and data share 3C0, with 3C1 behaving the same.
// RULE24 - Software keeps clocking mode bit 1 at zero in this mode.
module legacy_compat_display_regs (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  input  wire logic        mono_mode,
  input  wire logic        attr_flipflop_reset,
  input  wire logic        char_clk_en,
  input  wire logic        disp_en_raw,
  input  wire logic        cursor_raw,
  input  wire logic        char_attr_bit3,
  input  wire logic        vdisp_end,
  input  wire logic        pen_trigger,
  input  wire logic [15:0] pen_scan_addr,
  input  wire logic [3:0]  pixel_attr,
  input  wire logic        border_active,
  output logic             alpha_mode,
  output logic      [15:0] font_plane2_base,
  output logic      [8:0]  h_total_chars,
  output logic      [4:0]  hblank_end_count,
  output logic             hretrace_odd_start,
  output logic      [7:0]  v_total_low,
  output logic      [7:0]  vretrace_start_low,
  output logic      [3:0]  vretrace_end_low,
  output logic      [4:0]  cursor_first_row,
  output logic      [4:0]  cursor_last_row,
  output logic      [4:0]  underline_row,
  output logic      [4:0]  preset_row,
  output logic      [4:0]  max_scan_line,
  output logic      [4:0]  vblank_end,
  output logic      [4:0]  overflow_bits,
  output logic      [7:0]  crt_mode_bits,
  output logic      [7:0]  clocking_mode_bits,
  output logic      [2:0]  memory_mode_bits,
  output logic      [3:0]  attr_mode_bits,
  output logic      [3:0]  plane_enable_bits,
  output logic      [2:0]  read_plane,
  output logic      [1:0]  write_mode,
  output logic      [5:0]  gfx_mode_upper,
  output logic             disp_en_skewed,
  output logic             cursor_skewed,
  output logic             pixel_blue,
  output logic             pixel_green,
  output logic             pixel_red,
  output logic             pixel_secondary_blue,
  output logic             pixel_secondary_green,
  output logic             pixel_secondary_red,
  output logic      [1:0]  status_video,
  output logic             irq_out,
  output logic             irq_oe
);

  compat_regs_pkg::state_t s_q;
  compat_regs_pkg::state_t s_d;

  logic        pen_sync;
  logic [1:0]  cursor_skew;
  logic        crt_index_hit;
  logic        crt_data_hit;
  logic        attr_hit;
  logic [15:0] crt_index_port;
  logic [15:0] crt_data_port;
  logic [1:0]  font_region;
  compat_regs_pkg::colour_t pix_src;

  // The light-pen trigger is a pin, so it is synchronised before use.
  sync2 pen_sync_i (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .din     (pen_trigger),
    .dout    (pen_sync)
  );

  // Port addresses follow the display type.
  always_comb begin
    if (mono_mode) begin
      crt_index_port = `IO_CRT_INDEX_MONO; // see RULE5
      crt_data_port  = `IO_CRT_DATA_MONO;
    end else begin
      crt_index_port = `IO_CRT_INDEX_COLOR; // see RULE5
      crt_data_port  = `IO_CRT_DATA_COLOR;
    end
  end

  assign crt_index_hit = (io_addr == crt_index_port);
  assign crt_data_hit  = (io_addr == crt_data_port);
  // Both attribute ports decode identically. see RULE23
  assign attr_hit = (io_addr == `IO_ATTR_PORT_A) || (io_addr == `IO_ATTR_PORT_B);

  always_comb begin
    s_d = s_q;

    // Sequencer.
    if (io_wr && io_addr == `IO_SEQ_INDEX) begin
      s_d.seq_idx = io_wdata[2:0];
    end
    if (io_wr && io_addr == `IO_SEQ_DATA) begin
      unique case (s_q.seq_idx)
        `SEQ_CLOCKING_MODE:   s_d.seq_clocking_mode   = io_wdata;
        `SEQ_FONT_MAP_SELECT: s_d.seq_font_map_select = io_wdata;
        `SEQ_MEMORY_MODE:     s_d.seq_memory_mode     = io_wdata;
        default: begin
        end
      endcase
    end

    // Timing controller.
    if (io_wr && crt_index_hit) begin
      s_d.crt_index_pointer = io_wdata[4:0]; // see RULE6
    end
    if (io_wr && crt_data_hit) begin
      unique case (s_q.crt_index_pointer)
        `CRT_HORIZONTAL_TOTAL: s_d.crt_horizontal_total = io_wdata;
        `CRT_HBLANK_END:       s_d.crt_hblank_end       = io_wdata;
        `CRT_HRETRACE_END:     s_d.crt_hretrace_end     = io_wdata;
        `CRT_VERTICAL_TOTAL:   s_d.crt_vertical_total   = io_wdata;
        `CRT_OVERFLOW_BITS:    s_d.crt_overflow_bits    = io_wdata;
        `CRT_PRESET_ROW:       s_d.crt_preset_row       = io_wdata;
        `CRT_MAX_SCAN_LINE:    s_d.crt_max_scan_line    = io_wdata;
        `CRT_CURSOR_FIRST_ROW: s_d.crt_cursor_first_row = io_wdata;
        `CRT_CURSOR_LAST_ROW:  s_d.crt_cursor_last_row  = io_wdata;
        `CRT_VRETRACE_BEGIN:   s_d.crt_vretrace_begin   = io_wdata; // see RULE13
        `CRT_VRETRACE_FINISH:  s_d.crt_vretrace_finish  = io_wdata; // see RULE13
        `CRT_UNDERLINE_ROW:    s_d.crt_underline_row    = io_wdata;
        `CRT_VBLANK_END:       s_d.crt_vblank_end       = io_wdata;
        `CRT_MODE_CONTROL:     s_d.crt_mode_control     = io_wdata;
        default: begin
        end
      endcase
    end

    // Graphics controller.
    if (io_wr && io_addr == `IO_GFX_INDEX) begin
      s_d.gfx_idx = io_wdata[3:0];
    end
    if (io_wr && io_addr == `IO_GFX_DATA) begin
      unique case (s_q.gfx_idx)
        `GFX_READ_PLANE_SELECT: s_d.gfx_read_plane_select = io_wdata;
        `GFX_WRITE_MODE:        s_d.gfx_write_mode        = io_wdata;
        default: begin
        end
      endcase
    end

    // Attribute controller: one port alternates between index and data.
    if (io_wr && attr_hit) begin
      if (!s_q.attr_data_phase) begin
        s_d.attr_idx = io_wdata[4:0]; // see RULE23
      end else if (!s_q.attr_idx[4]) begin
        s_d.attr_palette_entries[s_q.attr_idx[3:0]] = io_wdata[5:0]; // see RULE20
      end else begin
        unique case (s_q.attr_idx)
          `ATTR_MODE_CONTROL:  s_d.attr_mode_control  = io_wdata;
          `ATTR_BORDER_COLOUR: s_d.attr_border_colour = io_wdata; // see RULE21
          `ATTR_PLANE_ENABLE:  s_d.attr_plane_enable  = io_wdata;
          default: begin
          end
        endcase
      end
      s_d.attr_data_phase = ~s_q.attr_data_phase;
    end
    // An external reset of the phase overrides a toggle in the same cycle,
    // so software always knows the port expects an index afterwards.
    if (attr_flipflop_reset) begin
      s_d.attr_data_phase = 1'b0;
    end

    // Interrupt latch: arming with bit 4 set lets the display end set it,
    // and with both bits low it is held clear. see RULE16
    if (s_d.crt_vretrace_finish[`VRF_IRQ_ARM_BIT] && vdisp_end) begin
      s_d.irq_latch = 1'b1;
    end else if (!s_d.crt_vretrace_finish[`VRF_IRQ_ARM_BIT]
                 && !s_d.crt_vretrace_finish[`VRF_IRQ_TRISTATE]) begin
      s_d.irq_latch = 1'b0;
    end

    // Light pen captures the scan address on each trigger rising edge.
    s_d.pen_prev = pen_sync;
    if (pen_sync && !s_q.pen_prev) begin
      s_d.pen_latch = pen_scan_addr;
    end

    // Reads: only the light-pen bytes are readable. see RULE13
    if (io_rd) begin
      s_d.rdata = `READ_IDLE_VALUE;
      if (crt_data_hit && s_q.crt_index_pointer == `CRT_VRETRACE_BEGIN) begin
        s_d.rdata = s_q.pen_latch[15:8];
      end else if (crt_data_hit && s_q.crt_index_pointer == `CRT_VRETRACE_FINISH) begin
        s_d.rdata = s_q.pen_latch[7:0];
      end
    end

    // Pixel colour: border during overscan, else the palette entry.
    s_d.pixel = pix_src; // see RULE20 RULE21

    // Video status multiplexer picks two of the six colour signals.
    unique case (s_q.attr_plane_enable[5:4])
      2'h0: s_d.status_video = {s_q.pixel[2], s_q.pixel[0]}; // see RULE22
      2'h2: s_d.status_video = {s_q.pixel[3], s_q.pixel[1]}; // see RULE22
      default: s_d.status_video = {s_q.pixel[5], s_q.pixel[4]}; // see RULE22
    endcase
  end

  always_comb begin
    if (border_active) begin
      pix_src = s_q.attr_border_colour[5:0]; // see RULE21
    end else begin
      pix_src = s_q.attr_palette_entries[pixel_attr]; // see RULE20
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Font selection: attribute bit 3 set picks map A. see RULE3
  always_comb begin
    if (char_attr_bit3) begin
      font_region = s_q.seq_font_map_select[3:2]; // see RULE1
    end else begin
      font_region = s_q.seq_font_map_select[1:0]; // see RULE2
    end
  end

  assign alpha_mode = s_q.seq_memory_mode[`MEM_MODE_ALPHA_BIT]; // see RULE4
  // Outside alpha mode the base stays at the first region. see RULE4
  assign font_plane2_base = alpha_mode ? {1'b0, font_region, 13'h0000} : 16'h0000;

  assign h_total_chars      = {1'b0, s_q.crt_horizontal_total} + `HTOTAL_BIAS; // see RULE7
  assign hblank_end_count   = s_q.crt_hblank_end[4:0]; // see RULE8
  assign hretrace_odd_start = s_q.crt_hretrace_end[`HRE_ODD_START_BIT]; // see RULE9
  assign v_total_low        = s_q.crt_vertical_total; // see RULE10
  assign vretrace_start_low = s_q.crt_vretrace_begin; // see RULE14
  assign vretrace_end_low   = s_q.crt_vretrace_finish[3:0];
  assign cursor_first_row   = s_q.crt_cursor_first_row[4:0];
  // Stored as written; the row comparison lives in the row counter. see RULE12
  assign cursor_last_row    = s_q.crt_cursor_last_row[4:0];
  assign underline_row      = s_q.crt_underline_row[4:0]; // see RULE17
  assign preset_row         = s_q.crt_preset_row[4:0];
  assign max_scan_line      = s_q.crt_max_scan_line[4:0];
  assign vblank_end         = s_q.crt_vblank_end[4:0];
  assign overflow_bits      = s_q.crt_overflow_bits[4:0];
  assign crt_mode_bits      = s_q.crt_mode_control;
  // Bit 1 is passed as written; keeping it zero is up to software. see RULE24
  assign clocking_mode_bits = s_q.seq_clocking_mode;
  assign memory_mode_bits   = s_q.seq_memory_mode[2:0];
  assign attr_mode_bits     = s_q.attr_mode_control[3:0];
  assign plane_enable_bits  = s_q.attr_plane_enable[3:0];
  assign read_plane         = s_q.gfx_read_plane_select[2:0]; // see RULE18
  assign gfx_mode_upper     = s_q.gfx_write_mode[7:2];

  // The illegal code 3 folds onto write mode 1. see RULE19
  assign write_mode = (s_q.gfx_write_mode[1:0] == 2'h3) ? 2'h1 : s_q.gfx_write_mode[1:0];

  // Cursor skew codes 0 and 1 both mean no delay. see RULE11
  assign cursor_skew = (s_q.crt_cursor_last_row[6:5] == 2'h0) ? 2'h0
                     : s_q.crt_cursor_last_row[6:5] - 2'h1;

  char_skew #(.DEPTH(3)) disp_skew_i (
    .sys_clk     (sys_clk),
    .rstn        (rstn),
    .char_clk_en (char_clk_en),
    .din         (disp_en_raw),
    .skew        (s_q.crt_hblank_end[6:5]), // see RULE8
    .dout        (disp_en_skewed)
  );

  char_skew #(.DEPTH(3)) cursor_skew_i (
    .sys_clk     (sys_clk),
    .rstn        (rstn),
    .char_clk_en (char_clk_en),
    .din         (cursor_raw),
    .skew        (cursor_skew), // see RULE11
    .dout        (cursor_skewed)
  );

  assign pixel_blue            = s_q.pixel[0];
  assign pixel_green           = s_q.pixel[1];
  assign pixel_red             = s_q.pixel[2];
  assign pixel_secondary_blue  = s_q.pixel[3];
  assign pixel_secondary_green = s_q.pixel[4];
  assign pixel_secondary_red   = s_q.pixel[5];
  assign status_video          = s_q.status_video;

  // irq_out always follows the latch; irq_oe is high only while bit 5 is low. see RULE15
  assign irq_out  = s_q.irq_latch;
  assign irq_oe   = ~s_q.crt_vretrace_finish[`VRF_IRQ_TRISTATE];
  assign io_rdata = s_q.rdata;

endmodule

/* sync2.sv */
module sync2 (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic din,
  output logic      dout
);

  logic meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule

/* tb_legacy_compat_display_regs.sv */
module tb_legacy_compat_display_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk, rstn, mono_mode, char_clk_en, disp_en_raw, cursor_raw;
  logic        char_attr_bit3, vdisp_end, pen_trigger, border_active;
  logic [15:0] pen_scan_addr, io_addr, font_plane2_base;
  logic [3:0]  pixel_attr;
  logic        io_wr, io_rd, attr_flipflop_reset, alpha_mode, hretrace_odd_start;
  logic [7:0]  io_wdata, io_rdata, v_total_low, vretrace_start_low, rd_val;
  logic [8:0]  h_total_chars;
  logic [4:0]  hblank_end_count, cursor_last_row, underline_row;
  logic [2:0]  read_plane;
  logic [1:0]  write_mode, status_video;
  logic        disp_en_skewed, cursor_skewed, irq_out, irq_oe;
  logic        pixel_blue, pixel_green, pixel_red;
  logic        pixel_secondary_blue, pixel_secondary_green, pixel_secondary_red;
  logic [5:0]  colours;
  int          miscompares, comparisons, cycles;
  assign colours = {pixel_secondary_red, pixel_secondary_green, pixel_secondary_blue,
                    pixel_red, pixel_green, pixel_blue};

  host_io host_io_i (.*);
  legacy_compat_display_regs legacy_compat_display_regs_i (.*, .vretrace_end_low(),
    .cursor_first_row(), .preset_row(), .max_scan_line(), .vblank_end(), .overflow_bits(),
    .crt_mode_bits(), .clocking_mode_bits(), .memory_mode_bits(), .attr_mode_bits(),
    .plane_enable_bits(), .gfx_mode_upper());

  always #50 sys_clk = ~sys_clk;
  // About 420 cycles are needed; the ceiling leaves margin.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic end_sim;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic crt(input logic [7:0] i, input logic [7:0] d);
    host_io_i.pair(mono_mode ? 16'h03B4 : 16'h03D4, i, d);
  endtask

  task automatic t_font;
    host_io_i.pair(16'h03C4, 8'h04, 8'h01);
    host_io_i.wr(16'h03C4, 8'h03);
    for (int i = 0; i < 4; i++) begin
      host_io_i.wr(16'h03C5, 8'(4 * i + 3 - i));
      char_attr_bit3 = 1'b1;
      #1 chk("font a", 16'(i * 8192), font_plane2_base);
      char_attr_bit3 = 1'b0;
      #1 chk("font b", 16'((3 - i) * 8192), font_plane2_base);
    end
    host_io_i.pair(16'h03C4, 8'h04, 8'h00);
    chk("alpha", 16'h0000, {15'h0000, alpha_mode});
    chk("font off", 16'h0000, font_plane2_base);
    $display("test font done");
  endtask

  task automatic t_crt;
    mono_mode = 1'b1;
    crt(8'hE0, 8'h5E);
    chk("h total", 16'h0060, 16'(h_total_chars));
    host_io_i.pair(16'h03D4, 8'h00, 8'h11);
    chk("h total mono", 16'h0060, 16'(h_total_chars));
    crt(8'h03, 8'h7F);
    chk("hblank end", 16'h001F, 16'(hblank_end_count));
    mono_mode = 1'b0;
    crt(8'h05, 8'h80);
    chk("odd start", 16'h0001, 16'(hretrace_odd_start));
    crt(8'h06, 8'hC3);
    chk("v total", 16'h00C3, 16'(v_total_low));
    crt(8'h14, 8'(9 - 1));
    chk("underline", 16'h0008, 16'(underline_row));
    $display("test timing done");
  endtask

  task automatic skew_run(input logic [7:0] idx, input int code, input int e, input bit cur);
    int n;
    n = 0;
    crt(idx, 8'(code * 32 + (cur ? 5 : 0)));
    if (cur) cursor_raw = 1'b1;
    else disp_en_raw = 1'b1;
    #1;
    while ((cur ? cursor_skewed : disp_en_skewed) !== 1'b1 && n < 8) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk(cur ? "cursor skew" : "enable skew", 16'(e), 16'(n));
    @(negedge sys_clk);
    cursor_raw = 1'b0;
    disp_en_raw = 1'b0;
    repeat (6) @(negedge sys_clk);
  endtask

  task automatic t_skew;
    for (int c = 0; c < 4; c++) begin
      skew_run(8'h03, c, c, 1'b0);
      skew_run(8'h0B, c, c < 2 ? 0 : c - 1, 1'b1);
    end
    chk("cursor end", 16'h0005, 16'(cursor_last_row));
    $display("test skew done");
  endtask

  task automatic vpulse;
    @(negedge sys_clk);
    vdisp_end = 1'b1;
    @(negedge sys_clk);
    vdisp_end = 1'b0;
  endtask

  task automatic t_irq;
    crt(8'h11, 8'h10);
    chk("irq oe", 16'h0001, 16'(irq_oe));
    vpulse();
    chk("irq set", 16'h0001, 16'(irq_out));
    crt(8'h11, 8'h30);
    chk("irq float", 16'h0000, 16'(irq_oe));
    crt(8'h11, 8'h20);
    @(negedge sys_clk);
    chk("irq kept", 16'h0001, 16'(irq_out));
    crt(8'h11, 8'h00);
    @(negedge sys_clk);
    chk("irq clear", 16'h0000, 16'(irq_out));
    vpulse();
    chk("irq disarmed", 16'h0000, 16'(irq_out));
    $display("test interrupt done");
  endtask

  task automatic t_pen;
    pen_scan_addr = 16'hA55A;
    pen_trigger = 1'b1;
    repeat (4) @(negedge sys_clk);
    crt(8'h10, 8'h77);
    chk("vr start", 16'h0077, 16'(vretrace_start_low));
    host_io_i.rd(16'h03D5, rd_val);
    chk("pen high", 16'h00A5, 16'(rd_val));
    host_io_i.wr(16'h03D4, 8'h11);
    host_io_i.rd(16'h03D5, rd_val);
    chk("pen low", 16'h005A, 16'(rd_val));
    host_io_i.rd(16'h03B5, rd_val);
    chk("mono port", 16'h0000, 16'(rd_val));
    pen_trigger = 1'b0;
    $display("test light pen done");
  endtask

  task automatic t_gfx;
    for (int i = 0; i < 4; i++) begin
      host_io_i.pair(16'h03CE, 8'h04, 8'(i));
      chk("read plane", 16'(i), 16'(read_plane));
      host_io_i.pair(16'h03CE, 8'h05, 8'(i));
      chk("write mode", 16'(i == 3 ? 1 : i), 16'(write_mode));
    end
    $display("test graphics done");
  endtask

  task automatic t_attr;
    logic [5:0] c;
    logic [1:0] e;
    for (int i = 0; i < 16; i++) host_io_i.attr(5'(i), 8'((i * 11) % 64), i[0]);
    for (int i = 0; i < 16; i++) begin
      pixel_attr = 4'(i);
      repeat (2) @(negedge sys_clk);
      chk("palette", 16'((i * 11) % 64), 16'(colours));
    end
    border_active = 1'b1;
    host_io_i.attr(5'h11, 8'h3F, 1'b0);
    repeat (2) @(negedge sys_clk);
    chk("border", 16'h003F, 16'(colours));
    host_io_i.attr(5'h11, 8'h00, 1'b1);
    repeat (2) @(negedge sys_clk);
    chk("border mono", 16'h0000, 16'(colours));
    border_active = 1'b0;
    c = 6'b011010;
    host_io_i.attr(5'h00, {2'b00, c}, 1'b0);
    pixel_attr = 4'h0;
    for (int k = 0; k < 4; k++) begin
      host_io_i.attr(5'h12, 8'(k * 16 + 15), 1'b1);
      repeat (3) @(negedge sys_clk);
      e = k == 0 ? {c[2], c[0]} : k == 2 ? {c[3], c[1]} : {c[5], c[4]};
      chk("status", 16'(e), 16'(status_video));
    end
    $display("test attribute done");
  endtask

  initial begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    {mono_mode, disp_en_raw, cursor_raw, char_attr_bit3, vdisp_end} = 5'h00;
    {pen_trigger, border_active} = 2'b00;
    char_clk_en = 1'b1;
    pen_scan_addr = 16'h0000;
    pixel_attr = 4'h0;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    rstn = 1'b1;
    chk("h total rst", 16'h0002, 16'(h_total_chars));
    chk("irq oe rst", 16'h0001, 16'(irq_oe));
    host_io_i.init();
    t_font();
    t_crt();
    t_skew();
    t_irq();
    t_pen();
    t_gfx();
    t_attr();
    end_sim();
  end
endmodule
